// ==== hw/ssl_regs.vh ====
`ifndef SSL_REGS_VH
`define SSL_REGS_VH

// Register indices
`define SSL_IDX_TRIG_MIX_OSC   8'h1f
`define SSL_IDX_TRIG_FIFO_DIV  8'h20
`define SSL_IDX_FACTORY        8'h21
`define SSL_IDX_LANE_ROUTING   8'h22

// Byte addresses, four times the index
`define SSL_ADDR_TRIG_MIX_OSC  8'h7c
`define SSL_ADDR_TRIG_FIFO_DIV 8'h80
`define SSL_ADDR_FACTORY       8'h84
`define SSL_ADDR_LANE_ROUTING  8'h88
`define SSL_ADDR_MIX_AB_SHADOW 8'h8c
`define SSL_ADDR_MIX_CD_SHADOW 8'h90
`define SSL_ADDR_MIX_AB_ACTIVE 8'h94
`define SSL_ADDR_MIX_CD_ACTIVE 8'h98
`define SSL_ADDR_EVENT_STATUS  8'h9c

// Reset values
`define SSL_RST_TRIG_MIX_OSC   16'h1140
`define SSL_RST_TRIG_FIFO_DIV  16'h2400
`define SSL_RST_LANE_ROUTING   16'h1b1b
`define SSL_RST_ZERO16         16'h0000

// Writable bits, reserved bits stay zero
`define SSL_WMASK_TRIG_MIX_OSC  16'hfffe
`define SSL_WMASK_TRIG_FIFO_DIV 16'hff01
`define SSL_WMASK_LANE_ROUTING  16'hffff

// Fields of trigger_select_mixer_oscillator
`define SSL_MIX_AB_MSB   15
`define SSL_MIX_AB_LSB   12
`define SSL_MIX_CD_MSB   11
`define SSL_MIX_CD_LSB   8
`define SSL_NCO_MSB      7
`define SSL_NCO_LSB      4
`define SSL_FMT_MSB      3
`define SSL_FMT_LSB      2
`define SSL_REG_TRIG_BIT 1

// Fields of trigger_select_fifo_divider
`define SSL_FIFO_WR_MSB  15
`define SSL_FIFO_WR_LSB  12
`define SSL_FIFO_RD_MSB  11
`define SSL_FIFO_RD_LSB  8
`define SSL_CLKDIV_BIT   0

// Source bit order inside a mask
`define SSL_SRC_REG      3
`define SSL_SRC_ALIGN    2
`define SSL_SRC_STROBE   1
`define SSL_SRC_LOW      0

// Formatter source codes
`define SSL_FMT_FRAMING  2'h0
`define SSL_FMT_ALIGN    2'h1

// Routing selector tops
`define SSL_IN_SEL_MSB   15
`define SSL_OUT_SEL_MSB  7

// Event status bits
`define SSL_EV_MIX_AB    0
`define SSL_EV_MIX_CD    1
`define SSL_EV_NCO       2
`define SSL_EV_FMT       3
`define SSL_EV_FIFO_WR   4
`define SSL_EV_FIFO_RD   5
`define SSL_EV_CLKDIV    6
`define SSL_EV_NUM       7

`endif

// ==== hw/ssl_trig_edge.v ====
`timescale 1ns/1ps
`default_nettype none

module ssl_trig_edge #(
  parameter N = 4
) (
  input  wire         clk_sys_i,
  input  wire         rst_n_i,
  input  wire [N-1:0] mask_i,
  input  wire [N-1:0] src_i,
  output wire         pulse_o
);

  reg  level_ff;
  reg  pulse_ff;
  wire nxt_level;

  // RQ12 OR of enabled sources
  assign nxt_level = |(mask_i & src_i);

  // RQ12 Rising edge detect
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      level_ff <= 1'b0;
      pulse_ff <= 1'b0;
    end else begin
      level_ff <= nxt_level;
      pulse_ff <= nxt_level & ~level_ff;
    end
  end

  assign pulse_o = pulse_ff;

endmodule // ssl_trig_edge

`default_nettype wire

// ==== hw/ssl_top.v ====
// Summary of operation
// RQ1 - A 4-bit mask picks which of register trigger, alignment pin, strobe pin and write updates AB mixer, reset 0001.
// RQ2 - A second 4-bit mask with the same order picks the CD mixer update sources, reset 0001.
// RQ3 - Mixer words written by software go live only when an enabled trigger of their path fires.
// RQ4 - A 4-bit mask of register trigger, alignment pin, strobe and framing pin re-aligns the oscillators, reset 0100.
// RQ5 - The formatter takes one source by a 2-bit code: 00 framing, 01 alignment, 10 and 11 none, reset 00.
// RQ6 - The trigger bit is a level software sets then clears, feeding every mask that enables it, reset 0.
// RQ7 - FIFO write and read sides have their own 4-bit masks, reset 0010 and 0100.
// RQ8 - One select bit aligns dividers from strobe when 0 or from the write-side framing or alignment when 1.
// RQ9 - Each channel path takes one of four input words by a 2-bit selector, A at the top, identity at reset.
// RQ10 - Each converter output takes one of four processed words by a 2-bit selector, identity at reset.
// RQ11 - Reserved bits and the factory word read as zero, and software writes zeros there.
// RQ12 - Each mask ORs its enabled sources and acts on the registered rising edge of the result.
`timescale 1ns/1ps
`default_nettype none
`include "ssl_regs.vh"

module ssl_top #(
  parameter W     = 16,
  parameter MIX_W = 32
) (
  input  wire             clk_sys_i,
  input  wire             rst_n_i,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [7:0]       paddr,
  input  wire [31:0]      pwdata,
  output wire [31:0]      prdata,
  output wire             pready,
  output wire             pslverr,
  input  wire             align_pin_i,
  input  wire             reference_strobe_pin_i,
  input  wire             framing_pin_i,
  input  wire [4*W-1:0]   in_words_i,
  input  wire [4*W-1:0]   proc_words_i,
  output wire [4*W-1:0]   chan_words_o,
  output wire [4*W-1:0]   conv_words_o,
  output wire [MIX_W-1:0] mixer_ab_active_o,
  output wire [MIX_W-1:0] mixer_cd_active_o,
  output wire             nco_align_o,
  output wire             formatter_align_o,
  output wire             fifo_wr_align_o,
  output wire             fifo_rd_align_o,
  output wire             clkdiv_align_o
);

  reg  [15:0]          trig_mix_osc_ff;
  reg  [15:0]          trig_fifo_div_ff;
  reg  [15:0]          lane_routing_ff;
  reg  [MIX_W-1:0]     mix_ab_shadow_ff;
  reg  [MIX_W-1:0]     mix_cd_shadow_ff;
  reg  [MIX_W-1:0]     mix_ab_active_ff;
  reg  [MIX_W-1:0]     mix_cd_active_ff;
  reg  [`SSL_EV_NUM-1:0] event_ff;
  reg  [`SSL_EV_NUM-1:0] nxt_event;
  reg  [31:0]          rd_data;
  reg                  addr_hit;

  wire                 wr_en;
  wire                 rd_en;
  wire                 reg_trig;
  wire                 wr_mix_ab;
  wire                 wr_mix_cd;
  wire [3:0]           src_mix_ab;
  wire [3:0]           src_mix_cd;
  wire [3:0]           src_sync;
  wire [3:0]           mask_mix_ab;
  wire [3:0]           mask_mix_cd;
  wire [3:0]           mask_nco;
  wire [3:0]           mask_fifo_wr;
  wire [3:0]           mask_fifo_rd;
  wire [1:0]           fmt_code;
  wire                 fmt_src;
  wire                 fmt_en;
  wire                 clkdiv_sel;
  wire                 clkdiv_src;
  wire                 pulse_mix_ab;
  wire                 pulse_mix_cd;
  wire                 pulse_nco;
  wire                 pulse_fmt;
  wire                 pulse_fifo_wr;
  wire                 pulse_fifo_rd;
  wire                 pulse_clkdiv;
  wire [`SSL_EV_NUM-1:0] ev_set;

  // Zero-wait APB slave
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~addr_hit;
  assign prdata  = rd_data;

  // Field extraction
  assign mask_mix_ab  = trig_mix_osc_ff[`SSL_MIX_AB_MSB:`SSL_MIX_AB_LSB];
  assign mask_mix_cd  = trig_mix_osc_ff[`SSL_MIX_CD_MSB:`SSL_MIX_CD_LSB];
  assign mask_nco     = trig_mix_osc_ff[`SSL_NCO_MSB:`SSL_NCO_LSB];
  assign fmt_code     = trig_mix_osc_ff[`SSL_FMT_MSB:`SSL_FMT_LSB];
  assign mask_fifo_wr = trig_fifo_div_ff[`SSL_FIFO_WR_MSB:`SSL_FIFO_WR_LSB];
  assign mask_fifo_rd = trig_fifo_div_ff[`SSL_FIFO_RD_MSB:`SSL_FIFO_RD_LSB];
  assign clkdiv_sel   = trig_fifo_div_ff[`SSL_CLKDIV_BIT];

  // RQ6 Register trigger level
  assign reg_trig = trig_mix_osc_ff[`SSL_REG_TRIG_BIT];

  assign wr_mix_ab = wr_en & (paddr == `SSL_ADDR_MIX_AB_SHADOW);
  assign wr_mix_cd = wr_en & (paddr == `SSL_ADDR_MIX_CD_SHADOW);

  // RQ1 AB mixer sources
  assign src_mix_ab = {reg_trig, align_pin_i, reference_strobe_pin_i, wr_mix_ab};
  // RQ2 CD mixer sources
  assign src_mix_cd = {reg_trig, align_pin_i, reference_strobe_pin_i, wr_mix_cd};
  // RQ4 Oscillator and FIFO sources
  assign src_sync   = {reg_trig, align_pin_i, reference_strobe_pin_i, framing_pin_i};

  // RQ5 Single formatter source
  assign fmt_src = (fmt_code == `SSL_FMT_FRAMING) ? framing_pin_i :
                   (fmt_code == `SSL_FMT_ALIGN)   ? align_pin_i   : 1'b0;
  assign fmt_en  = (fmt_code == `SSL_FMT_FRAMING) | (fmt_code == `SSL_FMT_ALIGN);

  // RQ8 Divider source select
  assign clkdiv_src = clkdiv_sel ?
    ((mask_fifo_wr[`SSL_SRC_LOW] & framing_pin_i) | (mask_fifo_wr[`SSL_SRC_ALIGN] & align_pin_i)) :
    reference_strobe_pin_i;

  ssl_trig_edge #(.N(4)) u_edge_mix_ab (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .mask_i    (mask_mix_ab),
    .src_i     (src_mix_ab),
    .pulse_o   (pulse_mix_ab)
  );

  ssl_trig_edge #(.N(4)) u_edge_mix_cd (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .mask_i    (mask_mix_cd),
    .src_i     (src_mix_cd),
    .pulse_o   (pulse_mix_cd)
  );

  ssl_trig_edge #(.N(4)) u_edge_nco (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .mask_i    (mask_nco),
    .src_i     (src_sync),
    .pulse_o   (pulse_nco)
  );

  // RQ7 FIFO write side
  ssl_trig_edge #(.N(4)) u_edge_fifo_wr (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .mask_i    (mask_fifo_wr),
    .src_i     (src_sync),
    .pulse_o   (pulse_fifo_wr)
  );

  // RQ7 FIFO read side
  ssl_trig_edge #(.N(4)) u_edge_fifo_rd (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .mask_i    (mask_fifo_rd),
    .src_i     (src_sync),
    .pulse_o   (pulse_fifo_rd)
  );

  ssl_trig_edge #(.N(1)) u_edge_fmt (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .mask_i    (fmt_en),
    .src_i     (fmt_src),
    .pulse_o   (pulse_fmt)
  );

  ssl_trig_edge #(.N(1)) u_edge_clkdiv (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .mask_i    (1'b1),
    .src_i     (clkdiv_src),
    .pulse_o   (pulse_clkdiv)
  );

  assign nco_align_o       = pulse_nco;
  assign formatter_align_o = pulse_fmt;
  assign fifo_wr_align_o   = pulse_fifo_wr;
  assign fifo_rd_align_o   = pulse_fifo_rd;
  assign clkdiv_align_o    = pulse_clkdiv;

  // Register writes
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      trig_mix_osc_ff  <= `SSL_RST_TRIG_MIX_OSC;
      trig_fifo_div_ff <= `SSL_RST_TRIG_FIFO_DIV;
      lane_routing_ff  <= `SSL_RST_LANE_ROUTING;
      mix_ab_shadow_ff <= {MIX_W{1'b0}};
      mix_cd_shadow_ff <= {MIX_W{1'b0}};
    end else if (wr_en) begin
      case (paddr)
        // RQ11 Reserved bits masked
        `SSL_ADDR_TRIG_MIX_OSC: begin
          trig_mix_osc_ff <= pwdata[15:0] & `SSL_WMASK_TRIG_MIX_OSC;
        end
        `SSL_ADDR_TRIG_FIFO_DIV: begin
          trig_fifo_div_ff <= pwdata[15:0] & `SSL_WMASK_TRIG_FIFO_DIV;
        end
        `SSL_ADDR_LANE_ROUTING: begin
          lane_routing_ff <= pwdata[15:0] & `SSL_WMASK_LANE_ROUTING;
        end
        `SSL_ADDR_MIX_AB_SHADOW: begin
          mix_ab_shadow_ff <= pwdata[MIX_W-1:0];
        end
        `SSL_ADDR_MIX_CD_SHADOW: begin
          mix_cd_shadow_ff <= pwdata[MIX_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // RQ3 Double-buffered mixer update
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mix_ab_active_ff <= {MIX_W{1'b0}};
      mix_cd_active_ff <= {MIX_W{1'b0}};
    end else begin
      if (pulse_mix_ab) begin
        mix_ab_active_ff <= mix_ab_shadow_ff;
      end
      if (pulse_mix_cd) begin
        mix_cd_active_ff <= mix_cd_shadow_ff;
      end
    end
  end

  assign mixer_ab_active_o = mix_ab_active_ff;
  assign mixer_cd_active_o = mix_cd_active_ff;

  // Event status, set wins over clear
  assign ev_set = {pulse_clkdiv, pulse_fifo_rd, pulse_fifo_wr, pulse_fmt,
                   pulse_nco, pulse_mix_cd, pulse_mix_ab};

  always @* begin
    nxt_event = event_ff;
    if (wr_en && (paddr == `SSL_ADDR_EVENT_STATUS)) begin
      nxt_event = event_ff & ~pwdata[`SSL_EV_NUM-1:0];
    end
    nxt_event = nxt_event | ev_set;
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      event_ff <= {`SSL_EV_NUM{1'b0}};
    end else begin
      event_ff <= nxt_event;
    end
  end

  // Read mux and decode
  always @* begin
    rd_data  = 32'h0000_0000;
    addr_hit = 1'b1;
    case (paddr)
      `SSL_ADDR_TRIG_MIX_OSC: begin
        rd_data[15:0] = trig_mix_osc_ff;
      end
      `SSL_ADDR_TRIG_FIFO_DIV: begin
        rd_data[15:0] = trig_fifo_div_ff;
      end
      // RQ11 Factory word reads zero
      `SSL_ADDR_FACTORY: begin
        rd_data[15:0] = `SSL_RST_ZERO16;
      end
      `SSL_ADDR_LANE_ROUTING: begin
        rd_data[15:0] = lane_routing_ff;
      end
      `SSL_ADDR_MIX_AB_SHADOW: begin
        rd_data[MIX_W-1:0] = mix_ab_shadow_ff;
      end
      `SSL_ADDR_MIX_CD_SHADOW: begin
        rd_data[MIX_W-1:0] = mix_cd_shadow_ff;
      end
      `SSL_ADDR_MIX_AB_ACTIVE: begin
        rd_data[MIX_W-1:0] = mix_ab_active_ff;
      end
      `SSL_ADDR_MIX_CD_ACTIVE: begin
        rd_data[MIX_W-1:0] = mix_cd_active_ff;
      end
      `SSL_ADDR_EVENT_STATUS: begin
        rd_data[`SSL_EV_NUM-1:0] = event_ff;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
    if (!rd_en) begin
      rd_data = 32'h0000_0000;
    end
  end

  // Lane routing per channel
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_lane
      wire [1:0] in_sel;
      wire [1:0] out_sel;
      reg  [W-1:0] chan_ff;
      reg  [W-1:0] conv_ff;
      reg  [W-1:0] nxt_chan;
      reg  [W-1:0] nxt_conv;

      // RQ9 Input word select
      assign in_sel  = lane_routing_ff[`SSL_IN_SEL_MSB-2*k -: 2];
      // RQ10 Output word select
      assign out_sel = lane_routing_ff[`SSL_OUT_SEL_MSB-2*k -: 2];

      always @* begin
        case (in_sel)
          2'h0: nxt_chan = in_words_i[0*W +: W];
          2'h1: nxt_chan = in_words_i[1*W +: W];
          2'h2: nxt_chan = in_words_i[2*W +: W];
          default: nxt_chan = in_words_i[3*W +: W];
        endcase
        case (out_sel)
          2'h0: nxt_conv = proc_words_i[0*W +: W];
          2'h1: nxt_conv = proc_words_i[1*W +: W];
          2'h2: nxt_conv = proc_words_i[2*W +: W];
          default: nxt_conv = proc_words_i[3*W +: W];
        endcase
      end

      always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          chan_ff <= {W{1'b0}};
          conv_ff <= {W{1'b0}};
        end else begin
          chan_ff <= nxt_chan;
          conv_ff <= nxt_conv;
        end
      end

      assign chan_words_o[k*W +: W] = chan_ff;
      assign conv_words_o[k*W +: W] = conv_ff;
    end
  endgenerate

endmodule // ssl_top

`default_nettype wire

// ==== tb/ssl_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssl_pin_model (
  input  wire logic        clk_sys_i,
  output var  logic        align_pin_o,
  output var  logic        strobe_pin_o,
  output var  logic        framing_pin_o,
  output var  logic [63:0] in_words_o,
  output var  logic [63:0] proc_words_o
);
  // Fixed words, word n in lane n
  initial begin
    {framing_pin_o, strobe_pin_o, align_pin_o} = 3'h0;
    in_words_o   = {16'h00a3, 16'h00a2, 16'h00a1, 16'h00a0};
    proc_words_o = {16'h00b3, 16'h00b2, 16'h00b1, 16'h00b0};
  end

  // Drive pins high for n cycles, then back low
  task automatic pulse(input logic [2:0] p, input int n);
    @(posedge clk_sys_i);
    {framing_pin_o, strobe_pin_o, align_pin_o} <= p;
    repeat (n) @(posedge clk_sys_i);
    {framing_pin_o, strobe_pin_o, align_pin_o} <= 3'h0;
  endtask
endmodule // ssl_pin_model
`default_nettype wire

// ==== tb/ssl_top_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssl_chk #(
  parameter W     = 16,
  parameter MIX_W = 32
) (
  input wire logic             clk_sys_i,
  input wire logic             rst_n_i,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic             align_pin_i,
  input wire logic             reference_strobe_pin_i,
  input wire logic             framing_pin_i,
  input wire logic [4*W-1:0]   in_words_i,
  input wire logic [4*W-1:0]   chan_words_o,
  input wire logic [MIX_W-1:0] mixer_ab_active_o,
  input wire logic             nco_align_o,
  input wire logic             formatter_align_o,
  input wire logic             clkdiv_align_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  wire wr_any = psel & penable & pwrite;

  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_quiet;
    (rst_n_i && $stable(in_words_i) && !psel) [*3];
  endsequence

  property p_ready;
    s_acc |-> pready;
  endproperty
  property p_fact;
    s_acc ##0 (!pwrite && paddr == 8'h84) |-> prdata == 32'h0 && !pslverr;
  endproperty
  property p_unmap;
    s_acc ##0 (paddr == 8'h00) |-> pslverr && prdata == 32'h0;
  endproperty
  property p_one;
    nco_align_o |=> !nco_align_o;
  endproperty
  property p_fmt;
    formatter_align_o |-> $past(framing_pin_i || align_pin_i);
  endproperty
  property p_div;
    clkdiv_align_o |-> $past(reference_strobe_pin_i || framing_pin_i || align_pin_i);
  endproperty
  property p_route;
    s_quiet |-> $stable(chan_words_o);
  endproperty
  property p_mix;
    $changed(mixer_ab_active_o) |->
      $past(wr_any, 2) || $past(wr_any, 3) || $past(align_pin_i || reference_strobe_pin_i, 2);
  endproperty

  a_ready: assert property (p_ready)
    else $error("no ready in access phase");
  a_fact: assert property (p_fact)
    else $error("factory word not zero");
  a_unmap: assert property (p_unmap)
    else $error("unmapped access not refused");
  a_one: assert property (p_one)
    else $error("oscillator pulse too long");
  a_fmt: assert property (p_fmt)
    else $error("formatter pulse without pin");
  a_div: assert property (p_div)
    else $error("divider pulse without pin");
  a_route: assert property (p_route)
    else $error("channel words moved while quiet");
  a_mix: assert property (p_mix)
    else $error("mixer word changed without trigger");
endmodule // ssl_chk

bind ssl_top ssl_chk #(.W(W), .MIX_W(MIX_W)) ssl_chk_i (
  .clk_sys_i, .rst_n_i, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .align_pin_i, .reference_strobe_pin_i, .framing_pin_i, .in_words_i, .chan_words_o,
  .mixer_ab_active_o, .nco_align_o, .formatter_align_o, .clkdiv_align_o
);
`default_nettype wire

// ==== tb/test_sync_source_and_lane_routing.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_sync_source_and_lane_routing;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} ssl_row_t;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0;
  logic [31:0] prdata, rd, mixer_ab_active_o, mixer_cd_active_o;
  logic [63:0] in_words_i, proc_words_i, chan_words_o, conv_words_o;
  logic        pready, pslverr, er, align_pin_i, reference_strobe_pin_i, framing_pin_i;
  logic        nco_align_o, formatter_align_o, fifo_wr_align_o, fifo_rd_align_o, clkdiv_align_o;
  logic [4:0]  pv;
  int          bad_count = 0, total_checks = 0, cyc_n = 0, cnt[5] = '{default:0}, base[5];
  ssl_row_t    rows[12] = '{
    '{1'b0, 8'h7c, 32'h0, 32'h1140, 1'b0}, '{1'b0, 8'h80, 32'h0, 32'h2400, 1'b0},
    '{1'b0, 8'h84, 32'h0, 32'h0000, 1'b0}, '{1'b0, 8'h88, 32'h0, 32'h1b1b, 1'b0},
    '{1'b1, 8'h7c, 32'hffff, 32'hfffe, 1'b0}, '{1'b1, 8'h80, 32'hffff, 32'hff01, 1'b0},
    '{1'b1, 8'h84, 32'hffff, 32'h0000, 1'b0}, '{1'b1, 8'h88, 32'h1234, 32'h1234, 1'b0},
    '{1'b1, 8'h00, 32'hffff, 32'h0000, 1'b1}, '{1'b0, 8'ha0, 32'h0, 32'h0000, 1'b1},
    '{1'b1, 8'h7c, 32'h1140, 32'h1140, 1'b0}, '{1'b1, 8'h80, 32'h2400, 32'h2400, 1'b0}};

  ssl_top ssl_top_i (
    .clk_sys_i, .rst_n_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .align_pin_i, .reference_strobe_pin_i, .framing_pin_i, .in_words_i, .proc_words_i, .chan_words_o,
    .conv_words_o, .mixer_ab_active_o, .mixer_cd_active_o, .nco_align_o, .formatter_align_o,
    .fifo_wr_align_o, .fifo_rd_align_o, .clkdiv_align_o
  );
  ssl_pin_model ssl_pin_model_i (
    .clk_sys_i, .align_pin_o(align_pin_i), .strobe_pin_o(reference_strobe_pin_i),
    .framing_pin_o(framing_pin_i), .in_words_o(in_words_i), .proc_words_o(proc_words_i)
  );

  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  // Pulse counters and run limit
  assign pv = {clkdiv_align_o, fifo_rd_align_o, fifo_wr_align_o, formatter_align_o, nco_align_o};
  always @(posedge clk_sys_i) begin
    for (int i = 0; i < 5; i++) if (pv[i] === 1'b1) cnt[i] <= cnt[i] + 1;
    cyc_n++;
    if (cyc_n == 6000) begin
      bad_count++;
      end_of_test;
    end
  end

  task check(input logic [63:0] g, input logic [63:0] x);
    total_checks++;
    if (g !== x) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do @(posedge clk_sys_i); while (pready !== 1'b1);
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task idle(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task do_reset;
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    idle(8);
    rst_n_i <= 1'b1;
    idle(2);
    check(chan_words_o, 64'h00a3_00a2_00a1_00a0);
    check(conv_words_o, 64'h00b3_00b2_00b1_00b0);
    check({mixer_ab_active_o, mixer_cd_active_o}, 64'h0);
    $display("reset test done");
  endtask

  task pins(input logic [2:0] p, input int n, input logic [4:0] x);
    base = cnt;
    ssl_pin_model_i.pulse(p, n);
    idle(5);
    for (int i = 0; i < 5; i++) check(64'(cnt[i] - base[i]), {63'h0, x[i]});
    $display("pin test %b done", p);
  endtask

  initial begin
    do_reset;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      check({31'h0, er, rd}, {31'h0, rows[i].e, rows[i].x});
      $display("row %0d done", i);
    end
    wr(8'h88, 32'he4e4);
    idle(2);
    check(chan_words_o, 64'h00a0_00a1_00a2_00a3);
    check(conv_words_o, 64'h00b0_00b1_00b2_00b3);
    wr(8'h8c, 32'h1234_5678);
    idle(3);
    check(mixer_ab_active_o, 32'h1234_5678);
    wr(8'h7c, 32'h4140);
    wr(8'h8c, 32'hcafe_0001);
    idle(4);
    check(mixer_ab_active_o, 32'h1234_5678);
    pins(3'b001, 1, 5'b01001);
    check(mixer_ab_active_o, 32'hcafe_0001);
    wr(8'h7c, 32'h4840);
    wr(8'h90, 32'h00c0_ffee);
    idle(4);
    check(mixer_cd_active_o, 32'h0);
    wr(8'h7c, 32'h4842);
    idle(4);
    check({mixer_ab_active_o, mixer_cd_active_o}, 64'hcafe_0001_00c0_ffee);
    wr(8'h7c, 32'h1180);
    base = cnt;
    wr(8'h7c, 32'h1182);
    idle(4);
    check(64'(cnt[0] - base[0]), 64'h1);
    wr(8'h7c, 32'h1140);
    pins(3'b010, 1, 5'b10100);
    pins(3'b100, 1, 5'b00010);
    pins(3'b001, 3, 5'b01001);
    wr(8'h7c, 32'h1134);
    wr(8'h80, 32'h5001);
    pins(3'b100, 1, 5'b10101);
    pins(3'b001, 1, 5'b10110);
    pins(3'b010, 1, 5'b00001);
    wr(8'h7c, 32'h1108);
    wr(8'h80, 32'h0000);
    pins(3'b111, 1, 5'b10000);
    wr(8'h7c, 32'h110c);
    pins(3'b111, 1, 5'b10000);
    apb(1'b0, 8'h9c, 32'h0);
    check(rd, 32'h7f);
    wr(8'h9c, 32'h7f);
    apb(1'b0, 8'h9c, 32'h0);
    check(rd, 32'h0);
    wr(8'h94, 32'h0);
    apb(1'b0, 8'h94, 32'h0);
    check(rd, 32'hcafe_0001);
    apb(1'b0, 8'h98, 32'h0);
    check(rd, 32'h00c0_ffee);
    apb(1'b0, 8'h8c, 32'h0);
    check(rd, 32'hcafe_0001);
    $display("status test done");
    do_reset;
    apb(1'b0, 8'h7c, 32'h0);
    check(rd, 32'h1140);
    end_of_test;
  end
endmodule // test_sync_source_and_lane_routing
`default_nettype wire
